// ==== rcp_pkg.sv ====
`default_nettype none
package rcp_pkg;
   // Printed register offsets, kept as word indices
   localparam logic [7:0] IDX_RSVD_A = 8'h20;
   localparam logic [7:0] IDX_SUM_HI = 8'h21;
   localparam logic [7:0] IDX_SUM_LO = 8'h22;
   localparam logic [7:0] IDX_RSVD_B = 8'h23;
   localparam logic [7:0] IDX_PULSE_W = 8'h24;
   localparam logic [7:0] IDX_RSVD_C = 8'h25;
   localparam logic [7:0] IDX_RX_CFG = 8'h26;
   // Byte address is four times the index
   localparam int ADDR_IDX_LSB = 2;
   localparam int ADDR_IDX_MSB = 9;
   // Reset values
   localparam logic [7:0] RST_RSVD_A = 8'h00;
   localparam logic [7:0] RST_SUM_HI = 8'hFF;
   localparam logic [7:0] RST_SUM_LO = 8'hFF;
   localparam logic [7:0] RST_RSVD_B = 8'h88;
   localparam logic [7:0] RST_PULSE_W = 8'h26;
   localparam logic [7:0] RST_RSVD_C = 8'h87;
   localparam logic [7:0] RST_RX_CFG = 8'h48;
   // Receiver gain field layout
   localparam int GAIN_LSB = 4;
   localparam int GAIN_MSB = 6;
   localparam logic [2:0] RST_GAIN = RST_RX_CFG[GAIN_MSB:GAIN_LSB];
   localparam logic [3:0] RX_CFG_LOW_RSVD = RST_RX_CFG[3:0];
   // Gain in dB per code
   localparam logic [5:0] GAIN_18DB = 6'h12;
   localparam logic [5:0] GAIN_23DB = 6'h17;
   localparam logic [5:0] GAIN_33DB = 6'h21;
   localparam logic [5:0] GAIN_38DB = 6'h26;
   localparam logic [5:0] GAIN_43DB = 6'h2B;
   localparam logic [5:0] GAIN_48DB = 6'h30;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== rcp_pulse_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcp_pulse_gen (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   // Control
   input wire logic carrierTick,
   input wire logic modStart,
   input wire logic [7:0] pulseWidthValue,
   // Output
   output logic modPulse_q
);
   import rcp_pkg::*;
   logic [7:0] cnt_q;
   logic [8:0] tickSeen_q;
   logic [7:0] widthSeen_q;

   // Pulse lasts setting plus one carrier ticks
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         modPulse_q <= 1'b0;
         cnt_q <= 8'h00;
      end else if (clkEn) begin
         if (modStart && !modPulse_q) begin
            modPulse_q <= 1'b1;
            cnt_q <= pulseWidthValue;
         end else if (modPulse_q && carrierTick) begin
            if (cnt_q == 8'h00) begin
               modPulse_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
      end
   end

   // Helper count of ticks seen during a pulse
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tickSeen_q <= 9'h000;
         widthSeen_q <= 8'h00;
      end else if (clkEn) begin
         if (modStart && !modPulse_q) begin
            tickSeen_q <= 9'h000;
            widthSeen_q <= pulseWidthValue;
         end else if (modPulse_q && carrierTick) begin
            tickSeen_q <= tickSeen_q + 9'h001;
         end
      end
   end

   property p_pulseWidth;
      @(posedge clk_sys) disable iff (!arst_n)
      $fell(modPulse_q) |-> tickSeen_q == {1'b0, widthSeen_q} + 9'h001;
   endproperty
   a_pulseWidth: assert property (p_pulseWidth)
      else $error("pulse width not setting plus one");
endmodule // rcp_pulse_gen
`default_nettype wire

// ==== rcp_gain_dec.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcp_gain_dec (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   // Gain code in, gain in dB out
   input wire logic [2:0] receiverGainField,
   output logic [5:0] gainDb_q
);
   import rcp_pkg::*;

   function automatic logic [5:0] decodeGain(input logic [2:0] code);
      case (code)
         3'h0, 3'h2: decodeGain = GAIN_18DB;
         3'h1, 3'h3: decodeGain = GAIN_23DB;
         3'h4: decodeGain = GAIN_33DB;
         3'h5: decodeGain = GAIN_38DB;
         3'h6: decodeGain = GAIN_43DB;
         3'h7: decodeGain = GAIN_48DB;
         default: decodeGain = GAIN_18DB;
      endcase
   endfunction

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         gainDb_q <= GAIN_33DB;
      end else if (clkEn) begin
         gainDb_q <= decodeGain(receiverGainField);
      end
   end

   property p_gainLow;
      @(posedge clk_sys) disable iff (!arst_n)
      clkEn && receiverGainField[2] == 1'b0
         |=> gainDb_q
         == ($past(receiverGainField[0]) ? GAIN_23DB : GAIN_18DB);
   endproperty
   a_gainLow: assert property (p_gainLow)
      else $error("low gain codes decoded wrong");

   property p_gainHigh;
      @(posedge clk_sys) disable iff (!arst_n)
      clkEn && receiverGainField == 3'h6 ##1 clkEn && $stable(receiverGainField)
         |=> gainDb_q == GAIN_43DB;
   endproperty
   a_gainHigh: assert property (p_gainHigh)
      else $error("code 110 not 43 dB");
endmodule // rcp_gain_dec
`default_nettype wire

// ==== rcp_config_page.sv ====
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Checksum high byte read-only, resets FFh
// - Checksum low byte read-only, resets FFh
// - Pulse width equals setting plus one
// - Width register read-write, resets 26h
// - Gain codes map to 18..48 dB
// - Receiver config resets 48h, gain writable
// - Reserved 20h reads 00h, no function
// - Reserved 23h reads 88h, no function
// - Reserved 25h reads 87h, no function
module rcp_config_page (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   // AXI4-Lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Checksum engine result
   input wire logic [15:0] checksumResult,
   input wire logic checksumLoad,
   // Modulation
   input wire logic carrierTick,
   input wire logic modStart,
   output logic modPulse,
   output logic [7:0] pulseWidthValue,
   // Receiver gain
   output logic [2:0] receiverGainField,
   output logic [5:0] receiverGainDb
);
   import rcp_pkg::*;

   logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
   logic [1:0] bResp_q, rResp_q;
   logic [31:0] rData_q;
   logic awHeld_q, wHeld_q;
   logic [31:0] awAddr_q, wData_q;
   logic [3:0] wStrb_q;
   logic awHeld_d, wHeld_d, bValid_d, rValid_d;
   logic awTake, wTake, arTake, doWrite;
   logic [8:0] wrDec, rdDec;
   logic [7:0] readByte;
   logic [7:0] sumHigh_q, sumLow_q, pulseWidth_q;
   logic [2:0] receiver_gain_field_q;

   // Map a byte address to {hit, index}
   function automatic logic [8:0] decodeAddr(input logic [31:0] addr);
      logic [7:0] idx;
      logic hit;
      idx = addr[ADDR_IDX_MSB:ADDR_IDX_LSB];
      hit = (addr[31:ADDR_IDX_MSB+1] == '0) && (addr[1:0] == 2'h0)
         && (idx >= IDX_RSVD_A) && (idx <= IDX_RX_CFG);
      decodeAddr = {hit, idx};
   endfunction

   assign awTake = s_axi_awvalid && awReady_q;
   assign wTake = s_axi_wvalid && wReady_q;
   assign arTake = s_axi_arvalid && arReady_q;
   assign doWrite = awHeld_q && wHeld_q && !bValid_q;
   assign wrDec = decodeAddr(awAddr_q);
   assign rdDec = decodeAddr(s_axi_araddr);

   // Next state of the write and read handshakes
   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      bValid_d = bValid_q;
      rValid_d = rValid_q;
      if (awTake) begin
         awHeld_d = 1'b1;
      end else if (doWrite) begin
         awHeld_d = 1'b0;
      end
      if (wTake) begin
         wHeld_d = 1'b1;
      end else if (doWrite) begin
         wHeld_d = 1'b0;
      end
      if (doWrite) begin
         bValid_d = 1'b1;
      end else if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
      if (arTake) begin
         rValid_d = 1'b1;
      end else if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
   end

   // Write channel handshake
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         bValid_q <= 1'b0;
         awReady_q <= 1'b0;
         wReady_q <= 1'b0;
         bResp_q <= RESP_OKAY;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= 4'h0;
      end else if (clkEn) begin
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         bValid_q <= bValid_d;
         awReady_q <= !awHeld_d && !bValid_d;
         wReady_q <= !wHeld_d && !bValid_d;
         if (awTake) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            bResp_q <= wrDec[8] ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Writable fields; other mapped registers ignore writes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pulseWidth_q <= RST_PULSE_W;
         receiver_gain_field_q <= RST_GAIN;
      end else if (clkEn && doWrite && wrDec[8] && wStrb_q[0]) begin
         if (wrDec[7:0] == IDX_PULSE_W) begin
            pulseWidth_q <= wData_q[7:0];
         end
         if (wrDec[7:0] == IDX_RX_CFG) begin
            receiver_gain_field_q <= wData_q[GAIN_MSB:GAIN_LSB];
         end
      end
   end

   // Checksum result bytes, loaded by the engine only
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sumHigh_q <= RST_SUM_HI;
         sumLow_q <= RST_SUM_LO;
      end else if (clkEn && checksumLoad) begin
         sumHigh_q <= checksumResult[15:8];
         sumLow_q <= checksumResult[7:0];
      end
   end

   // Read data selection
   always_comb begin
      case (rdDec[7:0])
         IDX_RSVD_A: readByte = RST_RSVD_A;
         IDX_SUM_HI: readByte = sumHigh_q;
         IDX_SUM_LO: readByte = sumLow_q;
         IDX_RSVD_B: readByte = RST_RSVD_B;
         IDX_PULSE_W: readByte = pulseWidth_q;
         IDX_RSVD_C: readByte = RST_RSVD_C;
         IDX_RX_CFG: readByte = {1'b0, receiver_gain_field_q, RX_CFG_LOW_RSVD};
         default: readByte = 8'h00;
      endcase
   end

   // Read channel handshake
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rValid_q <= 1'b0;
         arReady_q <= 1'b0;
         rData_q <= '0;
         rResp_q <= RESP_OKAY;
      end else if (clkEn) begin
         rValid_q <= rValid_d;
         arReady_q <= !rValid_d;
         if (arTake) begin
            rData_q <= rdDec[8] ? {24'h000000, readByte} : '0;
            rResp_q <= rdDec[8] ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   assign pulseWidthValue = pulseWidth_q;
   assign receiverGainField = receiver_gain_field_q;

   // Modulation pulse; software keeps the width legal
   rcp_pulse_gen u_pulse (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clkEn(clkEn),
      .carrierTick(carrierTick),
      .modStart(modStart),
      .pulseWidthValue(pulseWidth_q),
      .modPulse_q(modPulse)
   );

   rcp_gain_dec u_gain (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clkEn(clkEn),
      .receiverGainField(receiver_gain_field_q),
      .gainDb_q(receiverGainDb)
   );

   sequence s_readAt(logic [7:0] idx);
      clkEn && arTake && rdDec == {1'b1, idx};
   endsequence

   property p_readRsvdA;
      @(posedge clk_sys) disable iff (!arst_n)
      s_readAt(IDX_RSVD_A) |=> s_axi_rvalid && s_axi_rdata == 32'h00000000;
   endproperty
   a_readRsvdA: assert property (p_readRsvdA)
      else $error("reserved 20h not 00h");

   property p_readRsvdB;
      @(posedge clk_sys) disable iff (!arst_n)
      s_readAt(IDX_RSVD_B) |=> s_axi_rdata == 32'h00000088;
   endproperty
   a_readRsvdB: assert property (p_readRsvdB)
      else $error("reserved 23h not 88h");

   property p_readRsvdC;
      @(posedge clk_sys) disable iff (!arst_n)
      s_readAt(IDX_RSVD_C) |=> s_axi_rdata == 32'h00000087;
   endproperty
   a_readRsvdC: assert property (p_readRsvdC)
      else $error("reserved 25h not 87h");

   property p_sumHigh;
      @(posedge clk_sys) disable iff (!arst_n)
      clkEn && checksumLoad ##1 s_readAt(IDX_SUM_HI) && !checksumLoad
         |=> s_axi_rdata[7:0] == $past(checksumResult[15:8], 2);
   endproperty
   a_sumHigh: assert property (p_sumHigh)
      else $error("checksum high byte wrong");

   property p_sumLowRo;
      @(posedge clk_sys) disable iff (!arst_n)
      !checksumLoad |=> $stable(sumLow_q) && $stable(sumHigh_q);
   endproperty
   a_sumLowRo: assert property (p_sumLowRo)
      else $error("checksum byte changed without load");

   property p_widthWrite;
      @(posedge clk_sys) disable iff (!arst_n)
      clkEn && doWrite && wrDec == {1'b1, IDX_PULSE_W} && wStrb_q[0]
         |=> pulseWidthValue == $past(wData_q[7:0]);
   endproperty
   a_widthWrite: assert property (p_widthWrite)
      else $error("width register not written");

   property p_rxCfgRead;
      @(posedge clk_sys) disable iff (!arst_n)
      s_readAt(IDX_RX_CFG) |=> s_axi_rdata[7] == 1'b0
         && s_axi_rdata[3:0] == 4'h8
         && s_axi_rdata[6:4] == $past(receiverGainField);
   endproperty
   a_rxCfgRead: assert property (p_rxCfgRead)
      else $error("receiver config readback wrong");

   property p_writeResp;
      @(posedge clk_sys) disable iff (!arst_n)
      clkEn && doWrite |=> s_axi_bvalid
         && s_axi_bresp == ($past(wrDec[8]) ? RESP_OKAY : RESP_SLVERR);
   endproperty
   a_writeResp: assert property (p_writeResp)
      else $error("write response wrong");

   // Response waits for the master
   sequence s_respWaiting;
      s_axi_bvalid && !s_axi_bready;
   endsequence

   property p_respHold;
      @(posedge clk_sys) disable iff (!arst_n)
      s_respWaiting |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_respHold: assert property (p_respHold)
      else $error("write response dropped before taken");
endmodule // rcp_config_page
`default_nettype wire

// ==== rcp_config_page_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcp_config_page_tb_top;
   import rcp_pkg::*;
   logic clk_sys = 1'h0;
   logic arst_n = 1'h0;
   logic clkEn = 1'h1;
   logic [31:0] s_axi_awaddr = 32'h0;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'h0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'h0;
   logic [15:0] checksumResult = 16'h0;
   logic checksumLoad = 1'h0;
   logic carrierTick = 1'h0;
   logic modStart = 1'h0;
   logic modPulse;
   logic [7:0] pulseWidthValue;
   logic [2:0] receiverGainField;
   logic [5:0] receiverGainDb;
   logic [1:0] tickCnt = 2'h0;
   logic [31:0] rnd = 32'h5113;
   logic [7:0] mirror [7] = '{RST_RSVD_A, RST_SUM_HI, RST_SUM_LO, RST_RSVD_B,
      RST_PULSE_W, RST_RSVD_C, RST_RX_CFG};
   logic [1:0] wrQ [$];
   logic [33:0] rdQ [$];
   int n_mismatch = 0;
   int n_tests = 0;
   int cycCnt = 0;

   rcp_config_page u_rcp_config_page (.clk_sys(clk_sys), .arst_n(arst_n),
      .clkEn(clkEn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .checksumResult(checksumResult), .checksumLoad(checksumLoad),
      .carrierTick(carrierTick), .modStart(modStart), .modPulse(modPulse),
      .pulseWidthValue(pulseWidthValue),
      .receiverGainField(receiverGainField),
      .receiverGainDb(receiverGainDb));

   always #10 clk_sys = ~clk_sys;

   // Free carrier tick every third cycle
   always @(posedge clk_sys) begin
      tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
      carrierTick <= (tickCnt == 2'h2);
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   function automatic logic [31:0] adr(input int i);
      logic [7:0] x;
      x = IDX_RSVD_A + 8'(i);
      return {22'h0, x, 2'h0};
   endfunction

   function automatic logic [5:0] gdb(input logic [2:0] c);
      case (c)
         3'h0, 3'h2: return GAIN_18DB;
         3'h1, 3'h3: return GAIN_23DB;
         3'h4: return GAIN_33DB;
         3'h5: return GAIN_38DB;
         3'h6: return GAIN_43DB;
         default: return GAIN_48DB;
      endcase
   endfunction

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [1:0] er);
      bit awDone;
      bit wDone;
      wrQ.push_back(er);
      awDone = 1'h0;
      wDone = 1'h0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'h1;
      while (!(awDone && wDone)) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready === 1'h1) begin
            awDone = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready === 1'h1) begin
            wDone = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      // Some writes leave the response waiting
      if (a[2]) begin
         repeat (3) @(posedge clk_sys);
      end
      s_axi_bready <= 1'h1;
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
   endtask

   task automatic axiRead(input logic [31:0] a, input logic [33:0] e);
      rdQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
   endtask

   task automatic regWrite(input int i, input logic [7:0] d,
         input logic [3:0] s);
      axiWrite(adr(i), {24'hA5C3E1, d}, s, RESP_OKAY);
      if (s[0] && i == 4) begin
         mirror[4] = d;
      end
      if (s[0] && i == 6) begin
         mirror[6] = {1'h0, d[6:4], RX_CFG_LOW_RSVD};
      end
   endtask

   task automatic regRead(input int i);
      axiRead(adr(i), {24'h0, mirror[i], RESP_OKAY});
   endtask

   task automatic modRun(input logic [7:0] w);
      int n;
      int k;
      regWrite(4, w, 4'hF);
      chk({26'h0, pulseWidthValue}, {26'h0, w});
      modStart <= 1'h1;
      @(posedge clk_sys);
      modStart <= 1'h0;
      @(posedge clk_sys);
      // Pulse is up before this edge, so a tick here already counts
      chk({33'h0, modPulse}, {33'h0, 1'h1});
      n = (carrierTick === 1'h1) ? 1 : 0;
      k = 0;
      #1;
      while (modPulse === 1'h1 && k < 900) begin
         @(posedge clk_sys);
         if (carrierTick === 1'h1) begin
            n++;
         end
         modStart <= (k == 2 && w > 8'h2);
         k++;
         #1;
      end
      modStart <= 1'h0;
      chk(34'(n), 34'(w) + 34'h1);
   endtask

   // Bus results taken oldest first
   always @(posedge clk_sys) begin
      if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
         if (wrQ.size() == 0) begin
            chk(34'h0, 34'h1);
         end else begin
            chk({32'h0, s_axi_bresp}, {32'h0, wrQ.pop_front()});
         end
      end
      if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
         if (rdQ.size() == 0) begin
            chk(34'h0, 34'h1);
         end else begin
            chk({s_axi_rdata, s_axi_rresp}, rdQ.pop_front());
         end
      end
   end

   always @(posedge clk_sys) begin
      cycCnt++;
      if (cycCnt == 20000) begin
         n_mismatch++;
         test_done();
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'h1;
      repeat (2) @(posedge clk_sys);
      // Reset values of the whole page
      for (int i = 0; i < 7; i++) regRead(i);
      // Random writes everywhere, only width and gain stick
      for (int i = 0; i < 7; i++) begin
         rnd = xs(rnd);
         regWrite(i, rnd[7:0], 4'hF);
      end
      for (int i = 0; i < 7; i++) regRead(i);
      // Byte lane 0 disabled leaves the width alone
      rnd = xs(rnd);
      regWrite(4, rnd[7:0], 4'hE);
      regRead(4);
      // Every gain code, other bits random
      for (int c = 0; c < 8; c++) begin
         rnd = xs(rnd);
         regWrite(6, {rnd[7], 3'(c), rnd[3:0]}, 4'hF);
         regRead(6);
         repeat (3) @(posedge clk_sys);
         chk({25'h0, receiverGainField, receiverGainDb},
            {25'h0, 3'(c), gdb(3'(c))});
      end
      // Unmapped and unaligned places
      axiWrite(32'h9C, 32'hFF, 4'hF, RESP_SLVERR);
      axiWrite(32'h91, 32'hFF, 4'hF, RESP_SLVERR);
      axiRead(32'h7C, {32'h0, RESP_SLVERR});
      axiRead(32'h9C, {32'h0, RESP_SLVERR});
      for (int i = 0; i < 7; i++) regRead(i);
      // Checksum read only after the engine reports a result
      rnd = xs(rnd);
      checksumResult <= rnd[15:0];
      checksumLoad <= 1'h1;
      @(posedge clk_sys);
      checksumLoad <= 1'h0;
      mirror[1] = rnd[15:8];
      mirror[2] = rnd[7:0];
      regRead(1);
      regRead(2);
      // Clock enable low freezes the bytes against a load
      rnd = xs(rnd);
      clkEn <= 1'h0;
      checksumLoad <= 1'h1;
      checksumResult <= rnd[15:0];
      repeat (4) @(posedge clk_sys);
      clkEn <= 1'h1;
      checksumLoad <= 1'h0;
      regRead(1);
      regRead(2);
      // Widths kept well under half a bit period
      rnd = xs(rnd);
      modRun(8'h0);
      modRun(8'h3);
      modRun({5'h0, rnd[2:0]} + 8'h4);
      repeat (5) @(posedge clk_sys);
      test_done();
   end
endmodule // rcp_config_page_tb_top
`default_nettype wire
